// [logic/oscillator_source_select.v]
// oscillator source selection with APB registers
`include "osc_select_defines.vh"
`default_nettype none
module oscillator_source_select #(
   parameter SETTLE_CYCLES = `FAST_SETTLE_CYCLES
) (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // configuration word
   input wire [1:0] cfg_source,
   input wire cfg_clock_out_enable_n,
   input wire cfg_timer_enable,
   input wire cfg_watchdog_enable,
   // oscillator clocks as levels
   input wire primary_osc_input,
   input wire fast_internal_osc,
   input wire slow_internal_osc,
   input wire startup_osc,
   input wire [2:0] timer_clocks,
   // peripherals and sleep
   input wire [4:0] rc_requests,
   input wire sleeping,
   input wire [2:0] logic_cell_sel,
   input wire [4:0] periph_sel,
   // enables and pins
   output reg fast_osc_en,
   output reg slow_osc_en,
   output reg rc_clock_en,
   output wire system_clock,
   output wire internal_clock,
   output reg clock_pin_is_io,
   output reg clock_out_active,
   output reg [1:0] ext_power_mode,
   output reg [3:0] postscale_sel,
   // peripheral clocks
   output wire conv_clk,
   output wire wave_clk,
   output wire nco_clk,
   output wire pwm_clk,
   output wire t1_clk,
   output wire logic_cell_clk
);
   reg [3:0] internal_freq_select;
   reg [1:0] system_clock_select;
   reg fast_osc_ready;
   reg fast_osc_stable;
   reg slow_osc_ready;
   reg [15:0] settle_cnt;
   reg [1:0] src_latched;
   reg cfg_taken;
   reg block_clk;
   wire use_internal;
   wire fast_rate;
   wire next_fast_en;
   wire next_slow_en;
   wire wr;
   wire rd;
   wire int_sel;
   wire [6:0] sources;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;

   // ****************
   // registers
   // ****************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_freq_select <= `FREQ_RESET;
         system_clock_select <= `SEL_RESET;
      end else if (wr && paddr == `ADDR_CONTROL) begin
         // run-time source change
         internal_freq_select <= pwdata[`FREQ_LSB+3:`FREQ_LSB];
         system_clock_select <= pwdata[1:0];
      end
   end

   // status is read-only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         case (paddr)
            `ADDR_CONTROL:
               prdata <= {25'h0, internal_freq_select, 1'b0,
                          system_clock_select};
            `ADDR_STATUS:
               prdata <= {27'h0, fast_osc_ready, 2'b00, slow_osc_ready,
                          fast_osc_stable};
            `ADDR_CONFIG:
               prdata <= {29'h0, cfg_clock_out_enable_n, src_latched};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************
   // power-up configuration
   // ****************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_taken <= 1'b0;
         src_latched <= `SRC_INTERNAL;
         clock_pin_is_io <= 1'b1;
         clock_out_active <= 1'b0;
         ext_power_mode <= 2'b00;
      end else if (!cfg_taken) begin
         cfg_taken <= 1'b1;
         src_latched <= cfg_source;
         clock_pin_is_io <= (cfg_source == `SRC_INTERNAL);
         clock_out_active <= ~cfg_clock_out_enable_n;
         ext_power_mode <= cfg_source;
      end
   end

   // ****************
   // oscillator enables
   // ****************
   assign int_sel = system_clock_select[1];
   assign use_internal = cfg_taken & (int_sel |
                         (src_latched == `SRC_INTERNAL));
   assign fast_rate = internal_freq_select[3:1] != 3'b000;
   assign next_fast_en = fast_rate & use_internal;
   assign next_slow_en = (~fast_rate & use_internal) | cfg_timer_enable |
                         cfg_watchdog_enable;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_osc_en <= 1'b0;
         slow_osc_en <= 1'b0;
         rc_clock_en <= 1'b0;
         postscale_sel <= `FREQ_RESET;
      end else begin
         fast_osc_en <= next_fast_en;
         slow_osc_en <= next_slow_en;
         // request driven, also in sleep
         rc_clock_en <= |rc_requests | (sleeping & rc_clock_en &
                        |rc_requests);
         postscale_sel <= internal_freq_select;
      end
   end

   // ****************
   // status
   // ****************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_osc_ready <= 1'b0;
         fast_osc_stable <= 1'b0;
         slow_osc_ready <= 1'b0;
         settle_cnt <= 16'h0000;
      end else begin
         fast_osc_ready <= fast_osc_en & next_fast_en;
         slow_osc_ready <= slow_osc_en & next_slow_en;
         if (!(fast_osc_en & next_fast_en)) begin
            // cleared at once when stopped
            settle_cnt <= 16'h0000;
            fast_osc_stable <= 1'b0;
         end else if (settle_cnt == SETTLE_CYCLES[15:0] - 16'h0001) begin
            fast_osc_stable <= 1'b1;
         end else begin
            settle_cnt <= settle_cnt + 16'h0001;
         end
      end
   end

   // start-up oscillator until stable
   always @* begin
      if (!fast_rate)
         block_clk = slow_internal_osc;
      else if (!fast_osc_stable)
         block_clk = startup_osc;
      else
         block_clk = fast_internal_osc;
   end
   assign internal_clock = block_clk;

   // external clock vs internal block
   clock_switch u_switch (
      .pclk(pclk),
      .presetn(presetn),
      .old_clk(primary_osc_input),
      .new_clk(block_clk),
      .request(use_internal),
      .active(),
      .busy(),
      .clk_out(system_clock)
   );

   assign sources = {timer_clocks, slow_internal_osc, fast_internal_osc,
                     rc_clock_en, system_clock};

   periph_clock_route u_route (
      .sources(sources),
      .logic_cell_sel(logic_cell_sel),
      .conv_sel(periph_sel[0]),
      .wave_sel(periph_sel[1]),
      .nco_sel(periph_sel[2]),
      .pwm_sel(periph_sel[3]),
      .t1_sel(periph_sel[4]),
      .conv_clk(conv_clk),
      .wave_clk(wave_clk),
      .nco_clk(nco_clk),
      .pwm_clk(pwm_clk),
      .t1_clk(t1_clk),
      .logic_cell_clk(logic_cell_clk)
   );
endmodule
`default_nettype wire

// [logic/osc_select_defines.vh]
// constants for the oscillator source select block
`ifndef OSC_SELECT_DEFINES_VH
`define OSC_SELECT_DEFINES_VH
// ****************
// register map
// ****************
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CONFIG 12'h008
`define CONTROL_RESET 8'h38
`define FREQ_RESET 4'h7
`define SEL_RESET 2'h0
`define FREQ_LSB 3
`define STAT_FAST_READY 4
`define STAT_SLOW_READY 1
`define STAT_FAST_STABLE 0
// ****************
// source codes
// ****************
`define SRC_INTERNAL 2'h0
`define SRC_EXT_LOW 2'h1
`define SRC_EXT_MED 2'h2
`define SRC_EXT_HIGH 2'h3
// ****************
// timing
// ****************
`define CLK_PERIOD_NS 100
`define FAST_SETTLE_NS 2000
`define FAST_SETTLE_CYCLES ((`FAST_SETTLE_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`endif

// [logic/clock_switch.v]
// glitch-free switch between two clocks sampled as levels
`default_nettype none
module clock_switch (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // clocks as sampled levels
   input wire old_clk,
   input wire new_clk,
   input wire request,
   // result
   output reg active,
   output reg busy,
   output reg clk_out
);
   localparam S_IDLE = 2'd0;
   localparam S_FALL = 2'd1;
   localparam S_RISE = 2'd2;
   reg [1:0] state;
   reg old_d;
   reg new_d;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         old_d <= 1'b0;
         new_d <= 1'b0;
         active <= 1'b0;
         busy <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         old_d <= old_clk;
         new_d <= new_clk;
         case (state)
            S_IDLE: begin
               clk_out <= active ? new_clk : old_clk;
               if (request != active) begin
                  busy <= 1'b1;
                  state <= S_FALL;
               end
            end
            S_FALL: begin
               // wait falling edge of current clock
               if ((active ? new_d : old_d) &&
                   !(active ? new_clk : old_clk)) begin
                  clk_out <= 1'b0;
                  state <= S_RISE;
               end else begin
                  clk_out <= active ? new_clk : old_clk;
               end
            end
            S_RISE: begin
               // held low until rising edge of new clock
               clk_out <= 1'b0;
               if (!(active ? old_d : new_d) &&
                   (active ? old_clk : new_clk)) begin
                  active <= ~active;
                  busy <= 1'b0;
                  clk_out <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [logic/periph_clock_route.v]
// per-peripheral clock routing with permitted choices
`default_nettype none
module periph_clock_route (
   // sources: sys, rc, fast, slow, t0, t1, t2
   input wire [6:0] sources,
   // selects
   input wire [2:0] logic_cell_sel,
   input wire conv_sel,
   input wire wave_sel,
   input wire nco_sel,
   input wire pwm_sel,
   input wire t1_sel,
   // clocks out
   output wire conv_clk,
   output wire wave_clk,
   output wire nco_clk,
   output wire pwm_clk,
   output wire t1_clk,
   output wire logic_cell_clk
);
   // permitted pairs only, logic cell takes any source
   assign conv_clk = conv_sel ? sources[1] : sources[0];
   assign wave_clk = wave_sel ? sources[2] : sources[0];
   assign nco_clk = nco_sel ? sources[2] : sources[0];
   assign pwm_clk = pwm_sel ? sources[6] : sources[0];
   assign t1_clk = t1_sel ? sources[3] : sources[0];
   assign logic_cell_clk = (logic_cell_sel == 3'd7) ? sources[0] :
                           sources[logic_cell_sel];
endmodule
`default_nettype wire

// [tb/osc_props.sv]
// assertion checker for the oscillator source select block
`default_nettype none
module osc_props (
   // bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // causes
   input wire logic [1:0] cfg_source,
   input wire logic cfg_timer_enable,
   input wire logic cfg_watchdog_enable,
   input wire logic [2:0] timer_clocks,
   input wire logic [4:0] rc_requests,
   input wire logic [2:0] logic_cell_sel,
   input wire logic [4:0] periph_sel,
   // results
   input wire logic fast_osc_en,
   input wire logic slow_osc_en,
   input wire logic rc_clock_en,
   input wire logic system_clock,
   input wire logic [3:0] postscale_sel,
   input wire logic pwm_clk,
   input wire logic logic_cell_clk
);
// ***
// control shadow
// ***
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
logic [3:0] freq;
logic [1:0] sel;
logic [1:0] up;
wire logic wr = psel && penable && pwrite && paddr == 12'h000;
wire logic fast = freq[3:1] != 3'h0 && (cfg_source == 2'h0 || sel[1]);
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      freq <= 4'h7;
      sel <= 2'h0;
      up <= 2'h0;
   end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (wr) begin
         freq <= pwdata[6:3];
         sel <= pwdata[1:0];
      end
   end
end
sequence s_rd(a);
   psel && !penable && !pwrite && paddr == a;
endsequence
property p_rd_ctrl;
   s_rd(12'h000) |=> prdata == {25'h0, freq, 1'b0, sel};
endproperty
a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read");
property p_rd_none;
   psel && !penable && !pwrite && paddr > 12'h008 |=> prdata == 32'h0;
endproperty
a_rd_none: assert property (p_rd_none) else $error("unmapped read");
property p_freq;
   wr |=> ##[0:1] postscale_sel == freq;
endproperty
a_freq: assert property (p_freq) else $error("postscale select");
property p_fast;
   up == 2'h3 && fast == $past(fast) |-> fast_osc_en == fast;
endproperty
a_fast: assert property (p_fast) else $error("fast enable");
property p_rc;
   up != 2'h0 |-> rc_clock_en == |$past(rc_requests);
endproperty
a_rc: assert property (p_rc) else $error("rc clock enable");
property p_slow;
   cfg_timer_enable || cfg_watchdog_enable |=> slow_osc_en;
endproperty
a_slow: assert property (p_slow) else $error("slow enable");
property p_cell;
   logic_cell_sel[2] |-> logic_cell_clk == (logic_cell_sel == 3'h7 ?
      system_clock : timer_clocks[logic_cell_sel[1:0]]);
endproperty
a_cell: assert property (p_cell) else $error("logic cell clock");
property p_pwm;
   pwm_clk == (periph_sel[3] ? timer_clocks[2] : system_clock);
endproperty
a_pwm: assert property (p_pwm) else $error("pwm clock");
endmodule
bind oscillator_source_select osc_props u_props (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .cfg_source(cfg_source),
   .cfg_timer_enable(cfg_timer_enable),
   .cfg_watchdog_enable(cfg_watchdog_enable),
   .timer_clocks(timer_clocks),
   .rc_requests(rc_requests),
   .logic_cell_sel(logic_cell_sel),
   .periph_sel(periph_sel),
   .fast_osc_en(fast_osc_en),
   .slow_osc_en(slow_osc_en),
   .rc_clock_en(rc_clock_en),
   .system_clock(system_clock),
   .postscale_sel(postscale_sel),
   .pwm_clk(pwm_clk),
   .logic_cell_clk(logic_cell_clk)
);
`default_nettype wire

// [tb/ext_clock_src.sv]
// external logic-level clock source model
`default_nettype none
module ext_clock_src #(
   parameter int HALF = 2
) (
   // control
   input wire logic pclk,
   input wire logic run,
   // clock to the primary input
   output var logic clk
);
timeunit 1ns;
timeprecision 1ns;
int n = 0;
initial clk = 1'b0;
always @(posedge pclk) begin
   n <= (n + 1) % HALF;
   if (!run) clk <= 1'b0;
   else if (n == 0) clk <= !clk;
end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the oscillator source select block
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ns;
// ***
// stimulus and model
// ***
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, v, s = 32'h3A;
logic [1:0] src = 2'h0, cnt = 2'h0, pm;
logic ce_n = 1, te = 0, we = 0, fo = 0, so = 0, uo = 0, slp = 0, pri;
logic [2:0] tc = 3'h0, cs = 3'h0;
logic [4:0] rq = 5'h0, ps5 = 5'h0;
logic pready, pslverr, rc_en, sys, pio, coa, cc;
logic ic, cvc, wvc, ncc, pwc, t1c;
int n_errors = 0, cmp_count = 0, m_ctrl = 32'h38, k;
ext_clock_src #(.HALF(2)) u_ext (.pclk(pclk), .run(src != 2'h0), .clk(pri));
oscillator_source_select #(.SETTLE_CYCLES(8)) u_dut (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .cfg_source(src), .cfg_clock_out_enable_n(ce_n),
   .cfg_timer_enable(te), .cfg_watchdog_enable(we),
   .primary_osc_input(pri), .fast_internal_osc(fo), .slow_internal_osc(so),
   .startup_osc(uo), .timer_clocks(tc), .rc_requests(rq), .sleeping(slp),
   .logic_cell_sel(cs), .periph_sel(ps5), .fast_osc_en(), .slow_osc_en(),
   .rc_clock_en(rc_en), .system_clock(sys), .internal_clock(ic),
   .clock_pin_is_io(pio), .clock_out_active(coa), .ext_power_mode(pm),
   .postscale_sel(), .conv_clk(cvc), .wave_clk(wvc), .nco_clk(ncc),
   .pwm_clk(pwc), .t1_clk(t1c), .logic_cell_clk(cc));
always #50 pclk = ~pclk;
always @(posedge pclk) begin
   cnt <= cnt + 2'h1;
   fo <= ~fo;
   if (cnt[0]) uo <= ~uo;
   if (cnt == 2'h3) so <= ~so;
end
function automatic logic [31:0] rnd();
   s = s ^ (s << 13);
   s = s ^ (s >> 17);
   s = s ^ (s << 5);
   return s;
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp);
   cmp_count++;
   if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
   end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   @(posedge pclk);
   psel <= 1'b1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1'b1;
   do begin
      @(posedge pclk);
   end while (pready !== 1'b1);
   rd = prdata;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task rst(input logic [1:0] sr, input logic ce);
   @(posedge pclk);
   presetn <= 1'b0;
   src <= sr;
   ce_n <= ce;
   repeat (2) @(posedge pclk);
   presetn <= 1'b1;
   m_ctrl = 32'h38;
endtask
task stat(input logic [31:0] e, input int wait_n);
   repeat (wait_n) @(posedge pclk);
   apb(1'b0, 12'h004, 32'h0);
   chk(rd & 32'h13, e);
endtask
task close_out;
   $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
   if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
   else $display("*** FAIL ***");
   $finish;
endtask
initial begin
   #500000;
   n_errors++;
   close_out();
end
initial begin
   for (int i = 0; i < 4; i++) begin
      rst(i[1:0], i[0]);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, m_ctrl);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {29'h0, i[0], i[1:0]});
      chk(pio, i == 0);
      chk(coa, !i[0]);
      if (i != 0) begin
         chk(pm, i[1:0]);
         stat(32'h0, 0);
         k = 0;
         repeat (16) @(negedge pclk) k += sys;
         chk(k != 0, 1'b1);
      end
      $display("source test %0d done", i);
   end
   rst(2'h0, 1'b1);
   for (int i = 0; i < 6; i++) begin
      v = rnd();
      apb(1'b1, 12'h000, v);
      m_ctrl = v & 32'h7B;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, m_ctrl);
   end
   apb(1'b1, 12'h008, 32'h0);
   apb(1'b1, 12'h004, 32'hFF);
   apb(1'b0, 12'h008, 32'h0);
   chk(rd, 32'h4);
   apb(1'b0, 12'h010, 32'h0);
   chk(rd, 32'h0);
   chk(pslverr, 1'b0);
   $display("register test done");
   rst(2'h3, 1'b1);
   apb(1'b1, 12'h000, 32'h7A);
   k = 0;
   do begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
   end while (rd[4] !== 1'b1 && k < 20);
   chk(rd & 32'h13, 32'h10);
   @(negedge pclk);
   chk(ic, uo);
   stat(32'h11, 6);
   @(negedge pclk);
   chk(ic, fo);
   apb(1'b1, 12'h000, 32'h02);
   stat(32'h02, 4);
   @(negedge pclk);
   chk(ic, so);
   apb(1'b1, 12'h000, 32'h38);
   stat(32'h0, 4);
   we <= 1'b1;
   stat(32'h02, 4);
   te <= 1'b1;
   we <= 1'b0;
   stat(32'h02, 4);
   $display("oscillator test done");
   for (int i = 0; i < 8; i++) begin
      v = rnd();
      @(posedge pclk);
      rq <= v[4:0] & {5{v[5]}};
      slp <= v[6];
      tc <= v[9:7];
      ps5 <= v[14:10];
      cs <= i[2:0];
      @(posedge pclk);
      @(negedge pclk);
      chk(rc_en, |(v[4:0] & {5{v[5]}}));
      k = i == 7 ? 0 : i;
      chk(cc, ({tc, so, fo, rc_en, sys} >> k) & 7'h01);
      chk(cvc, ps5[0] ? rc_en : sys);
      chk(wvc, ps5[1] ? fo : sys);
      chk(ncc, ps5[2] ? fo : sys);
      chk(pwc, ps5[3] ? tc[2] : sys);
      chk(t1c, ps5[4] ? so : sys);
   end
   $display("routing test done");
   close_out();
end
endmodule
`default_nettype wire
